// File: spi_port_defines.vh
// Purpose: shared constants for the serial slave port
// Assumes: included by its bare name
// Notes:   frame layout and counts
`ifndef SPI_PORT_DEFINES_VH
`define SPI_PORT_DEFINES_VH
`define FRAME_BITS      16
`define CNT_W           5
`define ADDR_LSB        0
`define ADDR_MSB        6
`define SEL_BIT         7
`define DATA_LSB        8
`define DATA_MSB        15
`define ERR_BIT         15
`define CNT_ZERO        5'h0
`define FIFO_DEPTH      4
`define FIFO_AW         2
`define CNT_MAX         5'h1f
`define SYNC_PINS       3
`define PIN_SEL         2
`define PIN_CLK         1
`define PIN_DIN         0
`define PIN_IDLE        3'h4
`endif

// File: word_fifo.v
// Purpose: small first-in first-out buffer for received words
// Assumes: single clock, synchronous active-high reset
// Notes:   honest full and empty, no write when full, no read when empty
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  // handshakes
  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer wrap assumes depth is a power of two
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // memory write, no reset needed on data
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule // word_fifo
`default_nettype wire

// File: spi_slave_port.v
// Purpose: 16-bit serial slave port, oversampling the master's clock
// Assumes: ref_clk much faster than serial clock; pins are asynchronous
// Notes:   received words leave through a 4-word buffer after select rises
//
// Operation
// - one frame moves sixteen bits from master on serial input, master clocked.
// - falling select marks the start of a new frame.
// - received word is acted on only after select returns high.
// - serial output goes high impedance while select is high.
// - serial input sampled into receive shift register on each falling clock.
// - transmit register advances and drives next bit after each rising clock.
// - no pass-through of input bits; output carries only own response.
// - clock counts other than zero or sixteen discard word, flag next response.
// - word splits into address 6..0, selector bit 7, data 15..8.
// - frames received during restart are ignored, not interpreted.
`timescale 1ns/100ps
`default_nettype none
`include "spi_port_defines.vh"
module spi_slave_port #(
  parameter FRAME_BITS = `FRAME_BITS,
  parameter DEPTH      = `FIFO_DEPTH
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        select_n,
  input  wire        serial_clk,
  input  wire        serial_input,
  output reg         serial_output,
  output reg         serial_output_en_n,
  input  wire        restart_active,
  input  wire [15:0] response_word,
  output wire        response_load,
  output wire [6:0]  cmd_addr,
  output wire        cmd_sel,
  output wire [7:0]  cmd_data,
  output wire        cmd_valid,
  input  wire        cmd_ready,
  output reg         err_flag_ff,
  output reg         overflow_ff
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // the three pins share one loop; each bit has its own pair of flops
  wire [`SYNC_PINS-1:0] pin_raw;
  wire [`SYNC_PINS-1:0] pin_idle;
  wire [`SYNC_PINS-1:0] pin_sync;
  reg                   sel_d_ff;
  reg                   clk_d_ff;
  genvar                g;

  // pins gathered into one bus for the loop below
  assign pin_raw[`PIN_SEL] = select_n;
  assign pin_raw[`PIN_CLK] = serial_clk;
  assign pin_raw[`PIN_DIN] = serial_input;
  // reset to the idle levels, so no false edge follows reset
  assign pin_idle          = `PIN_IDLE;

  // two stages per pin; only the second stage is read by logic
  generate
    for (g = 0; g < `SYNC_PINS; g = g + 1) begin : g_sync
      reg first_ff;
      reg second_ff;
      always @(posedge ref_clk) begin
        if (rst) begin
          first_ff  <= pin_idle[g];
          second_ff <= pin_idle[g];
        end else begin
          first_ff  <= pin_raw[g];
          second_ff <= first_ff;
        end
      end
      assign pin_sync[g] = second_ff;
    end
  endgenerate

  // a third stage of select and clock gives the old level for edges;
  // it costs a cycle of latency but keeps the edge pulses glitch free
  always @(posedge ref_clk) begin
    if (rst) begin
      sel_d_ff <= pin_idle[`PIN_SEL];
      clk_d_ff <= pin_idle[`PIN_CLK];
    end else begin
      sel_d_ff <= pin_sync[`PIN_SEL];
      clk_d_ff <= pin_sync[`PIN_CLK];
    end
  end

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  wire sel_s     = pin_sync[`PIN_SEL];
  wire clk_s     = pin_sync[`PIN_CLK];
  wire din_s     = pin_sync[`PIN_DIN];
  // edges are one-cycle pulses; clock edges count only while selected
  wire sel_fall  = sel_d_ff & ~sel_s;
  wire sel_rise  = ~sel_d_ff & sel_s;
  wire active    = ~sel_s;
  wire clk_fall  = active & clk_d_ff & ~clk_s;
  wire clk_rise  = active & ~clk_d_ff & clk_s;

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  reg [FRAME_BITS-1:0] rx_shift_ff;
  reg [`CNT_W-1:0]     bit_cnt_ff;
  reg                  restart_seen_ff;
  reg                  clk_high_edge_ff;

  // lsb arrives first; shifting toward lsb puts the first bit at bit 0
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_shift_ff      <= {FRAME_BITS{1'b0}};
      bit_cnt_ff       <= `CNT_ZERO;
      restart_seen_ff  <= 1'b0;
      clk_high_edge_ff <= 1'b0;
    end else if (sel_s) begin
      bit_cnt_ff       <= `CNT_ZERO;
      restart_seen_ff  <= restart_active;
      clk_high_edge_ff <= 1'b0;
    end else begin
      if (clk_fall) begin
        rx_shift_ff <= {din_s, rx_shift_ff[FRAME_BITS-1:1]};
        // saturate, so a runaway frame cannot wrap back to a legal count
        if (bit_cnt_ff != `CNT_MAX) begin
          bit_cnt_ff <= bit_cnt_ff + 1'b1;
        end
      end
      if (restart_active) begin
        restart_seen_ff <= 1'b1;
      end
      if (sel_fall && clk_s) begin
        clk_high_edge_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // frame end: check, then hand over
  // ---------------------------------------------------------------
  wire count_ok   = (bit_cnt_ff == FRAME_BITS[`CNT_W-1:0]);
  wire count_zero = (bit_cnt_ff == `CNT_ZERO);
  // a clock standing high at either select edge spoils the frame
  wire frame_bad  = ~(count_ok | count_zero) | clk_high_edge_ff | clk_s;
  wire any_clocks = ~count_zero;
  wire fifo_in_ready;
  wire [FRAME_BITS-1:0] fifo_word;
  // restart at either end or anywhere between drops the word unread
  wire push_word  = sel_rise & count_ok & ~frame_bad & ~restart_seen_ff
                    & ~restart_active;

  // error is shown at the start of the next frame, then cleared
  // an error that lands on the clearing edge wins over the clear
  always @(posedge ref_clk) begin
    if (rst) begin
      err_flag_ff <= 1'b0;
      overflow_ff <= 1'b0;
    end else begin
      if (sel_rise && (frame_bad || (restart_seen_ff && any_clocks))) begin
        err_flag_ff <= 1'b1;
      end else if (sel_rise) begin
        err_flag_ff <= 1'b0;
      end
      if (push_word && !fifo_in_ready) begin
        overflow_ff <= 1'b1;
      end
    end
  end

  // a full buffer drops the new word; overflow stays set until reset
  word_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (rx_shift_ff),
    .in_valid  (push_word),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_word),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready)
  );

  // field split of the buffered word; fields stand until it is popped
  assign cmd_addr = fifo_word[`ADDR_MSB:`ADDR_LSB];
  assign cmd_sel  = fifo_word[`SEL_BIT];
  assign cmd_data = fifo_word[`DATA_MSB:`DATA_LSB];

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  reg [FRAME_BITS-1:0] tx_shift_ff;

  // response captured at select fall; the error flag is ORed into its bit 0, the first bit out
  assign response_load = sel_fall;

  // output holds only our own response, never the received stream
  always @(posedge ref_clk) begin
    if (rst) begin
      tx_shift_ff        <= {FRAME_BITS{1'b0}};
      serial_output      <= 1'b0;
      serial_output_en_n <= 1'b1;
    end else if (sel_s) begin
      serial_output_en_n <= 1'b1;
      serial_output      <= 1'b0;
    end else if (sel_fall) begin
      // first bit leaves at select fall, before any clock rise
      tx_shift_ff        <= {1'b0, response_word[FRAME_BITS-1:1]};
      serial_output      <= restart_active | err_flag_ff | response_word[0];
      serial_output_en_n <= 1'b0;
    end else if (clk_rise) begin
      tx_shift_ff   <= {1'b0, tx_shift_ff[FRAME_BITS-1:1]};
      serial_output <= restart_active | tx_shift_ff[0];
    end else if (restart_active) begin
      // restart holds the line high, so the master sees a dead frame
      serial_output <= 1'b1;
    end
  end
endmodule // spi_slave_port
`default_nettype wire

// File: spi_port_monitor.sv
// Purpose: pin-level checks of the serial slave port
// Assumes: ref_clk oversamples every pin
// Notes:   windows allow for the 2-ff pin syncs
`timescale 1ns/100ps
`default_nettype none
module spi_port_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic serial_output,
  input wire logic serial_output_en_n,
  input wire logic restart_active,
  input wire logic response_load,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic err_flag_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----
  // pin relations
  // ----
  a_load_after_fall: assert property ($fell(select_n) |-> ##[1:5] response_load)
    else $error("no load after select fall");
  a_load_single: assert property (response_load |=> !response_load)
    else $error("load longer than a cycle");
  a_hiz_idle: assert property (select_n [*5] |-> serial_output_en_n)
    else $error("output driven while deselected");
  a_push_after_rise: assert property ($rose(cmd_valid) |-> select_n)
    else $error("word queued inside a frame");
  a_restart_high: assert property ((restart_active && !serial_output_en_n) [*4] |-> serial_output)
    else $error("output not high in restart");
  // a low clock gives no shift, so the output has to hold
  a_out_steady: assert property ((!serial_clk && !select_n && !restart_active) [*6]
    |-> $stable(serial_output))
    else $error("output moved without a clock rise");
  a_valid_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
    else $error("queued word lost");
  a_err_at_end: assert property ($rose(err_flag_ff) |-> select_n)
    else $error("error flag set inside a frame");
  c_word: cover property ($rose(cmd_valid));
  c_err: cover property ($rose(err_flag_ff));
  c_restart: cover property (restart_active && !serial_output_en_n);
endmodule // spi_port_monitor
bind spi_slave_port spi_port_monitor spi_port_monitor_inst (.ref_clk, .rst, .select_n,
  .serial_clk, .serial_output, .serial_output_en_n, .restart_active, .response_load,
  .cmd_valid, .cmd_ready, .err_flag_ff);
`default_nettype wire

// File: spi_master_model.sv
// Purpose: master model that clocks frames into the slave port
// Assumes: 400 ns serial clock, idle low, bit 0 first
// Notes:   data line flips after a frame so stale bits never look valid
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  input  wire logic ref_clk,
  input  wire logic serial_output,
  output var  logic select_n,
  output var  logic serial_clk,
  output var  logic serial_input
);
  // idle bus: deselected, clock low
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    serial_input = 1'b0;
  end
  // ----
  // one frame of n clocks, half period 4 ref_clk
  // ----
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    int i;
    r = 16'h0000;
    select_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    for (i = 0; i < n; i++) begin
      repeat (2) @(negedge ref_clk);
      serial_input = w[i % 16]; // moves mid-low, clear of both clock edges
      repeat (2) @(negedge ref_clk);
      r[i % 16] = serial_output;
      serial_clk = 1'b1;
      repeat (4) @(negedge ref_clk);
      serial_clk = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    select_n = 1'b1;
    serial_input = ~serial_input;
    repeat (12) @(negedge ref_clk);
  endtask
endmodule // spi_master_model
`default_nettype wire

// File: sbc_spi_slave_port_test.sv
// Purpose: self-checking bench of the serial slave port
// Assumes: 50 ns ref_clk, stimulus on its falling edge
// Notes:   frames come whole from the master model
`timescale 1ns/100ps
`default_nettype none
module sbc_spi_slave_port_test;
  logic ref_clk = 1'b0, rst = 1'b1, restart_active = 1'b0, cmd_ready = 1'b0;
  logic [15:0] response_word = 16'h5a3c, r;
  wire logic select_n, serial_clk, serial_input, serial_output, serial_output_en_n;
  wire logic response_load, cmd_sel, cmd_valid, err_flag_ff, overflow_ff;
  wire logic [6:0] cmd_addr;
  wire logic [7:0] cmd_data;
  wire logic sdo_line = serial_output_en_n ? 1'bz : serial_output; // shared data wire
  int bad_count = 0, n_checks = 0, n_loads = 0;
  always #25 ref_clk = ~ref_clk;
  // response loads counted mid-cycle, where the pulse is settled
  always @(negedge ref_clk) begin
    if (response_load) n_loads++;
  end
  spi_slave_port spi_slave_port_inst (.ref_clk, .rst, .select_n, .serial_clk,
    .serial_input, .serial_output, .serial_output_en_n, .restart_active, .response_word,
    .response_load, .cmd_addr, .cmd_sel, .cmd_data, .cmd_valid, .cmd_ready,
    .err_flag_ff, .overflow_ff);
  spi_master_model spi_master_model_inst (.ref_clk, .serial_output(sdo_line),
    .select_n, .serial_clk, .serial_input);
  // ----
  // helpers
  // ----
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task frame(input logic [15:0] w, input int n);
    spi_master_model_inst.xfer(w, n, r);
  endtask
  task pop(input logic [15:0] exp);
    chk({cmd_data, cmd_sel, cmd_addr}, exp);
    cmd_ready = 1'b1;
    @(negedge ref_clk);
    cmd_ready = 1'b0;
    @(negedge ref_clk);
  endtask
  // ----
  // scenarios
  // ----
  task t_good;
    int loads;
    loads = n_loads;
    frame(16'ha5c3, 16);
    chk(16'(n_loads - loads), 16'h0001);
    chk(r, 16'h5a3c);
    chk({15'h0000, serial_output_en_n}, 16'h0001);
    pop(16'ha5c3);
    chk({15'h0000, cmd_valid}, 16'h0000);
  endtask
  task t_count;
    int k;
    int n_tab[4];
    n_tab = '{0, 1, 15, 17};
    for (k = 0; k < 4; k++) begin
      frame(16'h1234, n_tab[k]);
      chk({15'h0000, cmd_valid}, 16'h0000);
      chk({15'h0000, err_flag_ff}, {15'h0000, k > 0});
    end
    frame(16'h0f0f, 16);
    chk(r, 16'h5a3d);
    pop(16'h0f0f);
    chk({15'h0000, err_flag_ff}, 16'h0000);
  endtask
  task t_restart;
    restart_active = 1'b1;
    frame(16'h0f0f, 16);
    restart_active = 1'b0;
    chk(r, 16'hffff);
    chk({14'h0000, cmd_valid, err_flag_ff}, 16'h0001);
    frame(16'h0f0f, 16);
    chk(r, 16'h5a3d);
    pop(16'h0f0f);
  endtask
  // far side stalls: fifth word must be refused
  task t_fifo;
    int k;
    for (k = 0; k < 5; k++) frame({k[7:0], 8'h81}, 16);
    chk({15'h0000, overflow_ff}, 16'h0001);
    for (k = 0; k < 4; k++) pop({k[7:0], 8'h81});
    chk({15'h0000, cmd_valid}, 16'h0000);
  endtask
  // mid-run reset with a queued word, a pending error and overflow set
  task t_reset;
    frame(16'h00c3, 16);
    frame(16'h00c3, 3);
    chk({13'h0000, cmd_valid, err_flag_ff, overflow_ff}, 16'h0007);
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({12'h000, cmd_valid, err_flag_ff, overflow_ff, serial_output_en_n}, 16'h0001);
    frame(16'h00c3, 16);
    chk(r, 16'h5a3c);
    pop(16'h00c3);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence after a 4-cycle reset
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_good;
    t_count;
    t_restart;
    t_fifo;
    t_reset;
    stop_test;
  end
  // watchdog: about fourteen times the expected run
  initial begin
    #1500000;
    bad_count++;
    stop_test;
  end
endmodule // sbc_spi_slave_port_test
`default_nettype wire
